//--- itsc_crc8.sv
/*
 * Running 8-bit check byte over a stream of bytes, MSB of each byte first.
 * Assumes the caller restarts it at the first byte of each transaction.
 */
`timescale 1ns/1ps
module itsc_crc8
   import itsc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Byte stream
   input wire logic restart,
   input wire logic load,
   input wire logic [7:0] dataIn,
   // Result
   output logic [7:0] crcVal
);

   logic [7:0] crc_q;
   logic [7:0] seed;

   // Fold one byte into the register, one bit at a time.
   function automatic logic [7:0] step(input logic [7:0] c,
                                       input logic [7:0] d);
      logic [7:0] r;
      logic fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         fb = r[7] ^ d[i];
         r = {r[6:0], 1'b0};
         if (fb) begin
            r = r ^ CRC_POLY;
         end
      end
      return r;
   endfunction

   // A restart with a byte in the same cycle folds that byte into the preset.
   always_comb begin
      seed = restart ? CRC_INIT : crc_q;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         crc_q <= CRC_INIT;
      end else if (load) begin
         crc_q <= step(seed, dataIn);
      end else if (restart) begin
         crc_q <= CRC_INIT;
      end
   end

   assign crcVal = crc_q;

endmodule

//--- itsc_ctl.sv
/*
 * Behavioural I2C controller on the far side of the target.
 * Assumes the bench resolves both open-drain lines with pull-ups.
 */
`timescale 1ns/1ps
module itsc_ctl (
   // Resolved bus levels
   input wire logic scl,
   input wire logic sda,
   // Pull-down requests
   output logic sclLow,
   output logic sdaLow
);
   // Running check byte; the bench reads it to build its expectations.
   logic [7:0] crcRun = 8'hFF;
   initial begin
      sclLow = 1'h0;
      sdaLow = 1'h0;
   end
   function automatic logic [7:0] crcStep(input logic [7:0] c,
                                          input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? {r[6:0], 1'h0} ^ 8'h07 : {r[6:0], 1'h0};
      end
      return r;
   endfunction
   // Lets SCL go and waits, bounded, while the target stretches it.
   task automatic sclRise();
      int n;
      n = 0;
      sclLow = 1'h0;
      while (!scl && n < 9000) begin
         #50;
         n++;
      end
   endtask
   // One bit at a 400 ns period; data moves only while SCL is low.
   task automatic bitx(input logic b, output logic r);
      #100 sdaLow = !b;
      #100 sclRise();
      #100 r = sda;
      #100 sclLow = 1'h1;
   endtask
   // Start or repeated start, then the address byte.
   task automatic open(input logic [6:0] a, input logic rd, output logic ack);
      #100 sdaLow = 1'h0;
      #100 sclRise();
      #100 sdaLow = 1'h1;
      #100 sclLow = 1'h1;
      if (!rd) begin
         crcRun = 8'hFF;
      end
      wr({a, rd}, ack);
   endtask
   // check byte is sent like any byte
   task automatic wr(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], r);
      end
      bitx(1'h1, r);
      ack = !r;
      crcRun = crcStep(crcRun, d);
   endtask
   task automatic rd(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'h1, r);
         d[i] = r;
      end
      bitx(nack, r);
      crcRun = crcStep(crcRun, d);
   endtask
   // Stop leaves both lines released, so the clock stands still.
   task automatic stop();
      #100 sdaLow = 1'h1;
      #100 sclRise();
      #100 sdaLow = 1'h0;
      #100;
   endtask
endmodule

//--- itsc_pkg.sv
/*
 * Shared constants for the I2C target with clock stretching and CRC check.
 * Assumes a single system clock at CLK_FREQ_HZ; SCL and SDA arrive from pins.
 */
package itsc_pkg;

   // -----------------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------------
   localparam int CLK_FREQ_HZ = 20_000_000;
   localparam int STRETCH_TIMEOUT_US = 5000;
   // Longest allowed stretch, rounded down to whole cycles.
   localparam int STRETCH_TIMEOUT_CYC =
      STRETCH_TIMEOUT_US * (CLK_FREQ_HZ / 1_000_000);

   // -----------------------------------------------------------------------
   // Check byte
   // -----------------------------------------------------------------------
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'hFF;

   // -----------------------------------------------------------------------
   // Control word layout and framing
   // -----------------------------------------------------------------------
   localparam int CW_DIR_BIT = 23;
   localparam int CW_CRC_BIT = 22;
   localparam int CW_DLC_HI = 21;
   localparam int CW_DLC_LO = 20;
   localparam logic [3:0] CTRL_BYTES = 4'h3;
   localparam logic [1:0] DLC_16BIT = 2'h0;
   localparam logic [1:0] DLC_32BIT = 2'h1;
   localparam logic [3:0] LEN_16BIT = 4'h2;
   localparam logic [3:0] LEN_32BIT = 4'h4;
   localparam logic [3:0] LEN_64BIT = 4'h8;
   localparam logic [7:0] IDLE_FILL = 8'hFF;

   // -----------------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------------
   typedef enum {
      ST_IDLE, ST_RXBIT, ST_HOLD, ST_ACK,
      ST_TXWAIT, ST_TXBIT, ST_TXACK, ST_IGNORE
   } itsc_state_t;

   // Number of data bytes selected by the data length code.
   function automatic logic [3:0] itsc_data_bytes(input logic [1:0] code);
      logic [3:0] n;
      n = LEN_64BIT;
      if (code == DLC_16BIT) begin
         n = LEN_16BIT;
      end else if (code == DLC_32BIT) begin
         n = LEN_32BIT;
      end
      return n;
   endfunction

endpackage

//--- itsc_target.sv
/*
 * I2C target transaction engine: address match, byte receive and transmit,
 * clock stretching on pending events with a timeout, check byte handling.
 * Assumes open-drain SCL/SDA resolved outside; the service side runs on clk
 * and answers the start, receive and transmit events with one-cycle strobes.
 */
`timescale 1ns/1ps
module itsc_target
   import itsc_pkg::*;
#(
   parameter int TIMEOUT_CYC = STRETCH_TIMEOUT_CYC
)(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Bus pins, open drain
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOe,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Own target address
   input wire logic [6:0] tgtAddr,
   // Start event
   output logic startEvt,
   input wire logic startAck,
   // Receive event
   output logic [7:0] rxByte,
   output logic rxValid,
   input wire logic rxAck,
   // Transmit buffer
   output logic txReq,
   input wire logic [7:0] txData,
   input wire logic txLoad,
   // Transaction results
   output logic [23:0] ctrlWord,
   output logic wrCommit,
   output logic wrDiscard,
   output logic timeoutEvt
);

   localparam int TW = $clog2(TIMEOUT_CYC + 1);

   // -----------------------------------------------------------------------
   // Pin synchronisers and bus conditions
   // -----------------------------------------------------------------------
   logic sclMeta_q, sclSync_q, sclPrev_q;
   logic sdaMeta_q, sdaSync_q, sdaPrev_q;
   logic sclRise, sclFall, startCond, stopCond;

   // Both pins pass two flops; only the second and later stages are read.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sclMeta_q <= 1'b1;
         sclSync_q <= 1'b1;
         sclPrev_q <= 1'b1;
         sdaMeta_q <= 1'b1;
         sdaSync_q <= 1'b1;
         sdaPrev_q <= 1'b1;
      end else begin
         sclMeta_q <= sclIn;
         sclSync_q <= sclMeta_q;
         sclPrev_q <= sclSync_q;
         sdaMeta_q <= sdaIn;
         sdaSync_q <= sdaMeta_q;
         sdaPrev_q <= sdaSync_q;
      end
   end

   assign sclRise = sclSync_q & ~sclPrev_q;
   assign sclFall = ~sclSync_q & sclPrev_q;
   assign startCond = sclSync_q & sclPrev_q & sdaPrev_q & ~sdaSync_q;
   assign stopCond = sclSync_q & sclPrev_q & ~sdaPrev_q & sdaSync_q;

   // -----------------------------------------------------------------------
   // State
   // -----------------------------------------------------------------------
   itsc_state_t state_q;
   logic [3:0] bitCnt_q, byteIdx_q, txIdx_q;
   logic [7:0] shift_q, txShift_q, rxData_q, txBuf_q;
   logic [23:0] ctrlWord_q;
   logic isAddr_q, dirRead_q, wrSess_q, crcOk_q, crcSeen_q, ackd_q;
   logic startPend_q, startDone_q, rxPend_q, txFull_q, txReq_q;
   logic sclOe_q, sdaOe_q, wrCommit_q, wrDiscard_q, timeoutEvt_q;
   logic [TW-1:0] stretchCnt_q;
   logic timeoutHit;

   // Stretch decision and check byte feed.
   logic [3:0] dataLen;
   logic addrMatch, isCheck, holdGo, needData, sendCrc, txGo;
   logic crcRestart, crcLoad;
   logic [7:0] crcByte, txByte, crcVal;

   // -----------------------------------------------------------------------
   // Stretch timeout
   // -----------------------------------------------------------------------
   // stretch period timer
   always_ff @(posedge clk) begin
      if (sys_rst || !sclOe_q) begin
         stretchCnt_q <= '0;
      end else begin
         stretchCnt_q <= stretchCnt_q + 1'b1;
      end
   end

   assign timeoutHit = sclOe_q && (stretchCnt_q == TW'(TIMEOUT_CYC - 1));

   // -----------------------------------------------------------------------
   // Decisions taken while SCL is held
   // -----------------------------------------------------------------------
   always_comb begin
      dataLen = itsc_data_bytes(ctrlWord_q[CW_DLC_HI:CW_DLC_LO]);
      addrMatch = (shift_q[7:1] == tgtAddr);
      // check byte follows last data byte
      isCheck = !isAddr_q && ctrlWord_q[CW_CRC_BIT] &&
                (byteIdx_q == CTRL_BYTES + dataLen);
      needData = (txIdx_q < dataLen);
      sendCrc = !needData && ctrlWord_q[CW_CRC_BIT] && (txIdx_q == dataLen);
      holdGo = 1'b0;
      txGo = 1'b0;
      crcRestart = 1'b0;
      crcLoad = 1'b0;
      crcByte = shift_q;
      txByte = IDLE_FILL;
      case (state_q)
         ST_HOLD: begin
            if (isAddr_q) begin
               holdGo = startDone_q;
            end else begin
               // earlier byte still unserviced
               // The check byte waits too, so it never overtakes an event.
               holdGo = !rxPend_q;
            end
            crcRestart = holdGo && isAddr_q && !shift_q[0];
            crcLoad = holdGo && !isCheck;
         end
         ST_TXWAIT: begin
            txGo = needData ? txFull_q : 1'b1;
            if (needData) begin
               txByte = txBuf_q;
            end else if (sendCrc) begin
               txByte = crcVal;
            end
            crcLoad = txGo && needData;
            crcByte = txBuf_q;
         end
         default: begin
            holdGo = 1'b0;
         end
      endcase
   end

   itsc_crc8 crcUnit (
      .clk(clk),
      .sys_rst(sys_rst),
      .restart(crcRestart),
      .load(crcLoad),
      .dataIn(crcByte),
      .crcVal(crcVal)
   );

   // -----------------------------------------------------------------------
   // Service events: start, receive, transmit buffer
   // -----------------------------------------------------------------------
   // Hardware sets win over service strobes in the same cycle.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         startPend_q <= 1'b0;
         startDone_q <= 1'b0;
         rxPend_q <= 1'b0;
         rxData_q <= 8'h00;
         txFull_q <= 1'b0;
         txBuf_q <= 8'h00;
         txReq_q <= 1'b0;
      end else begin
         if (rxAck) begin
            rxPend_q <= 1'b0;
         end
         if (txLoad && !txFull_q) begin
            txBuf_q <= txData;
            txFull_q <= 1'b1;
         end
         if (timeoutHit) begin
            startPend_q <= 1'b0;
            startDone_q <= 1'b0;
            txReq_q <= 1'b0;
         end else if (state_q == ST_HOLD) begin
            if (isAddr_q) begin
               // start raised only after receive serviced
               if (!startPend_q && !startDone_q && !rxPend_q) begin
                  startPend_q <= 1'b1;
               end
               if (startPend_q && startAck) begin
                  startPend_q <= 1'b0;
                  startDone_q <= 1'b1;
               end
               if (holdGo) begin
                  startDone_q <= 1'b0;
               end
            end else if (holdGo && !isCheck) begin
               rxData_q <= shift_q;
               rxPend_q <= 1'b1;
            end
         end else if (state_q == ST_TXWAIT) begin
            txReq_q <= needData && !txFull_q && !txLoad;
            if (txGo && needData) begin
               txFull_q <= 1'b0;
            end
         end
      end
   end

   // -----------------------------------------------------------------------
   // Bit and byte sequencer
   // -----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         bitCnt_q <= 4'h0;
         byteIdx_q <= 4'h0;
         txIdx_q <= 4'h0;
         shift_q <= 8'h00;
         txShift_q <= 8'h00;
         ctrlWord_q <= 24'h000000;
         isAddr_q <= 1'b0;
         dirRead_q <= 1'b0;
         wrSess_q <= 1'b0;
         crcOk_q <= 1'b0;
         crcSeen_q <= 1'b0;
         ackd_q <= 1'b0;
         sclOe_q <= 1'b0;
         sdaOe_q <= 1'b0;
         wrCommit_q <= 1'b0;
         wrDiscard_q <= 1'b0;
         timeoutEvt_q <= 1'b0;
      end else begin
         wrCommit_q <= 1'b0;
         wrDiscard_q <= 1'b0;
         timeoutEvt_q <= 1'b0;
         if (timeoutHit) begin
            // abandon and wait for next start
            state_q <= ST_IGNORE;
            sclOe_q <= 1'b0;
            sdaOe_q <= 1'b0;
            wrSess_q <= 1'b0;
            timeoutEvt_q <= 1'b1;
         end else if (startCond) begin
            state_q <= ST_RXBIT;
            bitCnt_q <= 4'h0;
            isAddr_q <= 1'b1;
            sdaOe_q <= 1'b0;
         end else if (stopCond) begin
            state_q <= ST_IDLE;
            sdaOe_q <= 1'b0;
            if (wrSess_q && !ctrlWord_q[CW_DIR_BIT] &&
                byteIdx_q >= CTRL_BYTES + dataLen) begin
               if (ctrlWord_q[CW_CRC_BIT] && !(crcSeen_q && crcOk_q)) begin
                  wrDiscard_q <= 1'b1;
               end else begin
                  wrCommit_q <= 1'b1;
               end
            end
            wrSess_q <= 1'b0;
         end else begin
            case (state_q)
               ST_RXBIT: begin
                  if (sclRise) begin
                     shift_q <= {shift_q[6:0], sdaSync_q};
                     bitCnt_q <= bitCnt_q + 4'h1;
                  end else if (sclFall && bitCnt_q == 4'h8) begin
                     if (isAddr_q && !addrMatch) begin
                        state_q <= ST_IGNORE;
                     end else begin
                        sclOe_q <= 1'b1;
                        state_q <= ST_HOLD;
                     end
                  end
               end
               ST_HOLD: begin
                  if (holdGo) begin
                     if (isAddr_q) begin
                        dirRead_q <= shift_q[0];
                        txIdx_q <= 4'h0;
                        if (!shift_q[0]) begin
                           byteIdx_q <= 4'h0;
                           wrSess_q <= 1'b1;
                           crcOk_q <= 1'b0;
                           crcSeen_q <= 1'b0;
                        end
                     end else begin
                        if (isCheck) begin
                           crcOk_q <= (shift_q == crcVal);
                           crcSeen_q <= 1'b1;
                        end else if (byteIdx_q < CTRL_BYTES) begin
                           ctrlWord_q <= {ctrlWord_q[15:0], shift_q};
                        end
                        if (byteIdx_q != 4'hF) begin
                           byteIdx_q <= byteIdx_q + 4'h1;
                        end
                     end
                     sdaOe_q <= 1'b1;
                     sclOe_q <= 1'b0;
                     state_q <= ST_ACK;
                  end
               end
               ST_ACK: begin
                  if (sclFall) begin
                     sdaOe_q <= 1'b0;
                     isAddr_q <= 1'b0;
                     bitCnt_q <= 4'h0;
                     if (dirRead_q) begin
                        sclOe_q <= 1'b1;
                        state_q <= ST_TXWAIT;
                     end else begin
                        state_q <= ST_RXBIT;
                     end
                  end
               end
               ST_TXWAIT: begin
                  if (txGo) begin
                     // bytes leave in load order, MSB first
                     txShift_q <= {txByte[6:0], 1'b0};
                     sdaOe_q <= ~txByte[7];
                     bitCnt_q <= 4'h1;
                     if (txIdx_q != 4'hF) begin
                        txIdx_q <= txIdx_q + 4'h1;
                     end
                     sclOe_q <= 1'b0;
                     state_q <= ST_TXBIT;
                  end
               end
               ST_TXBIT: begin
                  if (sclFall) begin
                     if (bitCnt_q < 4'h8) begin
                        sdaOe_q <= ~txShift_q[7];
                        txShift_q <= {txShift_q[6:0], 1'b0};
                        bitCnt_q <= bitCnt_q + 4'h1;
                     end else begin
                        sdaOe_q <= 1'b0;
                        state_q <= ST_TXACK;
                     end
                  end
               end
               ST_TXACK: begin
                  if (sclRise) begin
                     ackd_q <= ~sdaSync_q;
                  end else if (sclFall) begin
                     if (ackd_q) begin
                        sclOe_q <= 1'b1;
                        state_q <= ST_TXWAIT;
                     end else begin
                        state_q <= ST_IGNORE;
                     end
                  end
               end
               default: begin
                  sdaOe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // -----------------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------------
   // Open-drain pins only ever pull low; the enables carry the level.
   assign sclOut = 1'b0;
   assign sdaOut = 1'b0;
   assign sclOe = sclOe_q;
   assign sdaOe = sdaOe_q;
   assign startEvt = startPend_q;
   assign rxByte = rxData_q;
   assign rxValid = rxPend_q;
   assign txReq = txReq_q;
   assign ctrlWord = ctrlWord_q;
   assign wrCommit = wrCommit_q;
   assign wrDiscard = wrDiscard_q;
   assign timeoutEvt = timeoutEvt_q;

endmodule

//--- itsc_target_props.sv
/*
 * Checker for the I2C target: stretch, service and result timing.
 * Assumes it is bound to itsc_target and sees only its ports.
 */
`timescale 1ns/1ps
module itsc_target_props
   import itsc_pkg::*;
#(
   parameter int TIMEOUT_CYC = STRETCH_TIMEOUT_CYC
)(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Bus drive
   input wire logic sclOe,
   input wire logic sdaOe,
   // Service side
   input wire logic startEvt,
   input wire logic startAck,
   input wire logic rxValid,
   input wire logic rxAck,
   input wire logic txReq,
   input wire logic txLoad,
   // Results
   input wire logic wrCommit,
   input wire logic wrDiscard,
   input wire logic timeoutEvt
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Length of the running stretch; a release clears it.
   int stretchLen_q;
   always_ff @(posedge clk) begin
      stretchLen_q <= (sys_rst || !sclOe) ? 0 : stretchLen_q + 1;
   end
   property p_start_hold;
      startEvt && !startAck && !timeoutEvt |=> startEvt || timeoutEvt;
   endproperty
   a_start_hold: assert property (p_start_hold) else $error("start lost");
   property p_start_rel;
      startEvt && startAck |=> !startEvt ##1 (sdaOe && !sclOe);
   endproperty
   a_start_rel: assert property (p_start_rel) else $error("no ack");
   property p_start_order;
      $rose(startEvt) |-> !rxValid && sclOe;
   endproperty
   a_start_order: assert property (p_start_order) else $error("order");
   property p_rx_hold;
      sclOe && rxValid && !rxAck && !timeoutEvt |=> sclOe || timeoutEvt;
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("early release");
   property p_tx_rel;
      txReq && txLoad |=> !txReq ##1 !sclOe;
   endproperty
   a_tx_rel: assert property (p_tx_rel) else $error("tx release");
   property p_stretch_lim;
      stretchLen_q <= TIMEOUT_CYC;
   endproperty
   a_stretch_lim: assert property (p_stretch_lim) else $error("too long");
   property p_to_drop;
      timeoutEvt |=> !sclOe && !sdaOe && !startEvt && !txReq;
   endproperty
   a_to_drop: assert property (p_to_drop) else $error("not dropped");
   property p_result;
      wrCommit || wrDiscard |-> !(wrCommit && wrDiscard)
         ##1 (!wrCommit && !wrDiscard);
   endproperty
   a_result: assert property (p_result) else $error("bad result");
   c_discard: cover property (wrDiscard);
   c_timeout: cover property (timeoutEvt);
   c_tx_load: cover property (txReq && txLoad);
endmodule

bind itsc_target itsc_target_props #(.TIMEOUT_CYC(TIMEOUT_CYC))
   itsc_target_props_inst (.*);

//--- test_i2c_target_stretch_crc.sv
/*
 * Self-checking bench for the I2C target with stretch and check byte.
 * Assumes the controller model and the checker are compiled alongside.
 */
`timescale 1ns/1ps
module test_i2c_target_stretch_crc;
   import itsc_pkg::*;
   localparam int TO_CYC = 200;
   localparam logic [6:0] OWN_ADDR = 7'h2A;
   logic clk, sys_rst, sclOut, sclOe, sdaOut, sdaOe, mScl, mSda;
   logic startEvt, startAck, rxValid, rxAck, txReq, txLoad;
   logic wrCommit, wrDiscard, timeoutEvt;
   logic [7:0] rxByte, txData;
   logic [23:0] ctrlWord;
   logic [15:0] seed = 16'h20C0;
   logic [7:0] rxQ[$], txQ[$];
   logic resQ[$];
   int numErrors = 0, checksDone = 0, toSeen = 0, cyc = 0, rxDly = 0;
   logic holdStart = 1'h0;
   // Pull-ups: a line is low while any party pulls it.
   wire logic sclIn = (sclOe ? sclOut : 1'h1) && !mScl;
   wire logic sdaIn = (sdaOe ? sdaOut : 1'h1) && !mSda;
   itsc_target #(.TIMEOUT_CYC(TO_CYC)) itsc_target_inst (
      .tgtAddr(OWN_ADDR), .*);
   itsc_ctl itsc_ctl_inst (.scl(sclIn), .sda(sdaIn), .sclLow(mScl),
      .sdaLow(mSda));
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   // Xorshift source for data bytes and service delays.
   function automatic logic [7:0] xs();
      seed ^= seed << 7;
      seed ^= seed >> 9;
      seed ^= seed << 8;
      return seed[7:0];
   endfunction
   task automatic tallyAndFinish();
      if (numErrors == 0 && checksDone > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [23:0] e,
                      input logic [23:0] g);
      checksDone++;
      if (g !== e) begin
         numErrors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // Watchdog and watcher: results are matched against the oldest note.
   always @(posedge clk) begin
      cyc++;
      if (cyc > 60000) begin
         numErrors++;
         tallyAndFinish();
      end
      if (rxAck) chk("rxByte", rxQ.pop_front(), rxByte);
      if (wrCommit || wrDiscard) chk("wrDiscard", resQ.pop_front(), wrDiscard);
      if (timeoutEvt) toSeen++;
   end
   // Service side: answers each event after a random wait, except a start while holdStart is set.
   initial begin
      forever begin
         @(posedge clk);
         if (startEvt && !holdStart) begin
            repeat (xs() % 8) @(posedge clk);
            startAck <= 1'h1;
            @(posedge clk);
            startAck <= 1'h0;
         end else if (rxValid) begin
            repeat (rxDly + xs() % 4) @(posedge clk);
            rxAck <= 1'h1;
            @(posedge clk);
            rxAck <= 1'h0;
         end else if (txReq) begin
            repeat (xs() % 8) @(posedge clk);
            txData <= txQ.pop_front();
            txLoad <= 1'h1;
            @(posedge clk);
            txLoad <= 1'h0;
         end
      end
   end
   task automatic send(input logic [7:0] d);
      logic a;
      rxQ.push_back(d);
      itsc_ctl_inst.wr(d, a);
      chk("ack", 1'h1, a);
   endtask
   // Address with write, then the control word, top byte first.
   task automatic head(input logic [23:0] cw);
      logic a;
      itsc_ctl_inst.open(OWN_ADDR, 1'h0, a);
      chk("addrAck", 1'h1, a);
      for (int i = 2; i >= 0; i--) send(cw[i*8 +: 8]);
      chk("ctrlWord", cw, ctrlWord);
   endtask
   // With the check byte off, a write commits whatever it carries.
   task automatic wrTxn(input logic [1:0] dlc, input logic bad,
                        input logic crcOn);
      logic [7:0] c;
      logic a;
      head({1'h0, crcOn, dlc, 4'h0, xs(), xs()});
      for (int i = 0; i < (2 << dlc); i++) send(xs());
      c = itsc_ctl_inst.crcRun ^ {7'h00, bad};
      if (crcOn) itsc_ctl_inst.wr(c, a);
      resQ.push_back(bad && crcOn);
      itsc_ctl_inst.stop();
   endtask
   task automatic rdTxn(input logic [1:0] dlc);
      logic [7:0] e[$];
      logic [7:0] g, c;
      logic a;
      head({2'h3, dlc, 4'h0, xs(), xs()});
      for (int i = 0; i < (2 << dlc); i++) e.push_back(xs());
      txQ = e;
      itsc_ctl_inst.open(OWN_ADDR, 1'h1, a);
      chk("rdAck", 1'h1, a);
      foreach (e[i]) begin
         itsc_ctl_inst.rd(1'h0, g);
         chk("rdData", e[i], g);
      end
      c = itsc_ctl_inst.crcRun;
      itsc_ctl_inst.rd(1'h1, g);
      chk("rdCrc", c, g);
      itsc_ctl_inst.stop();
   endtask
   initial begin
      logic a;
      sys_rst = 1'h1;
      startAck = 1'h0;
      rxAck = 1'h0;
      txLoad = 1'h0;
      txData = 8'h00;
      repeat (3) @(posedge clk);
      sys_rst <= 1'h0;
      repeat (4) @(posedge clk);
      // Every data length with good and bad check bytes, then a read.
      for (int c = 0; c < 3; c++) begin
         wrTxn(c[1:0], 1'h0, 1'h1);
         wrTxn(c[1:0], 1'h1, 1'h1);
         rdTxn(c[1:0]);
      end
      wrTxn(2'h0, 1'h1, 1'h0);
      // A foreign address is left alone.
      itsc_ctl_inst.open(OWN_ADDR ^ 7'h01, 1'h0, a);
      chk("foreignAck", 1'h0, a);
      itsc_ctl_inst.stop();
      // Start never serviced: the stretch must give up and free the bus.
      holdStart = 1'h1;
      itsc_ctl_inst.open(OWN_ADDR, 1'h0, a);
      chk("lateAck", 1'h0, a);
      itsc_ctl_inst.stop();
      holdStart = 1'h0;
      chk("timeouts", 24'h1, 24'(toSeen));
      // Slow receive service: bytes and the repeated start queue up.
      rxDly = 150;
      wrTxn(2'h1, 1'h0, 1'h1);
      rdTxn(2'h0);
      rxDly = 0;
      repeat (400) @(posedge clk);
      chk("notesLeft", 24'h0, 24'(rxQ.size() + resQ.size()));
      tallyAndFinish();
   end
endmodule
